// file: design/cfgio_map.svh
/*
  Offsets, field positions, reset values and timing counts of the
  configurable I/O port block. Assumes inclusion by bare name.
*/
`ifndef CFGIO_MAP_SVH
`define CFGIO_MAP_SVH

// ==========================================================
// Register offsets (byte addresses; data, cfga and cfgb each span four words, one per port)
`define CFGIO_OFF_DATA 8'h00
`define CFGIO_OFF_CFGA 8'h10
`define CFGIO_OFF_CFGB 8'h20
`define CFGIO_OFF_AIN_DIS 8'h30
`define CFGIO_OFF_STATUS 8'h34
`define CFGIO_OFF_BANK_MASK 8'hf0

// ==========================================================
// Reset values
`define CFGIO_RST_LATCH 8'hff
`define CFGIO_RST_CFGA 8'hff
`define CFGIO_RST_CFGB 8'h00
`define CFGIO_RST_AIN_DIS 8'h00

// ==========================================================
// Pin positions, index is port * 8 + bit
`define CFGIO_PIN_RST 13
`define CFGIO_PIN_TMR 10
`define CFGIO_PIN_XOUT 24
`define CFGIO_PIN_XIN 25
`define CFGIO_MASK_4P 32'h03003c3f
`define CFGIO_MASK_3P 32'h00033c3f

// ==========================================================
// Status fields
`define CFGIO_ST_CNT_LSB 0
`define CFGIO_ST_RPE 6
`define CFGIO_ST_CLK_LSB 7
`define CFGIO_ST_3P 9
`define CFGIO_ST_POR 10

// ==========================================================
// Timing
`define CFGIO_CLK_NS 40
`define CFGIO_GLITCH_NS 60
`define CFGIO_GLITCH_CYC \
  ((`CFGIO_GLITCH_NS + `CFGIO_CLK_NS - 1) / `CFGIO_CLK_NS)

`endif

// file: design/cfgio_pkg.sv
/*
  Types of the configurable I/O port block.
  Assumes nothing of its surroundings.
*/
package cfgio_pkg;

  // ==========================================================
  // Output types, code is {cfga bit, cfgb bit}
  typedef enum logic [1:0] {
    CFGIO_QUASI = 2'b00,
    CFGIO_PUSH = 2'b01,
    CFGIO_INPUT = 2'b10,
    CFGIO_OPEN = 2'b11
  } cfgio_mode_e;

  // ==========================================================
  // Clock source selection from the user configuration
  typedef enum logic [1:0] {
    CFGIO_CLK_ONCHIP = 2'b00,
    CFGIO_CLK_EXTIN = 2'b01,
    CFGIO_CLK_XTAL = 2'b10,
    CFGIO_CLK_RSVD = 2'b11
  } cfgio_clksrc_e;

endpackage

// file: design/cfgio_deglitch.sv
/*
  Glitch suppression stage for one pin input.
  Assumes the pin level is already synchronous to clk_i.
*/
`include "cfgio_map.svh"

module cfgio_deglitch #(
  parameter int unsigned CYC = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_i,
  output logic out_o
);
  import cfgio_pkg::*;

  logic [1:0] cnt_q;
  logic out_q;

  // ==========================================================
  // Level must differ for CYC cycles in a row before it passes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 2'h0;
      out_q <= 1'b0;
    end else if (in_i == out_q) begin
      cnt_q <= 2'h0;
    end else if (cnt_q == 2'(CYC - 1)) begin
      cnt_q <= 2'h0;
      out_q <= in_i;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  assign out_o = out_q;

  // ==========================================================
  sequence s_held_two;
    $past(in_i, 1) == out_q && $past(in_i, 2) == out_q;
  endsequence

  chk_glitch_held: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $changed(out_q) |-> s_held_two
  ) else $error("Filtered level changed on a short pulse");

endmodule

// file: design/cfgio_pin.sv
/*
  Pad driver decode for one port pin.
  Assumes the mode given is already restricted for special pins.
*/
`include "cfgio_map.svh"

module cfgio_pin (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire cfgio_pkg::cfgio_mode_e mode_i,
  input wire logic latch_i,
  output logic pad_o,
  output logic pad_oe_o,
  output logic pad_pu_o
);
  import cfgio_pkg::*;

  // ==========================================================
  always_comb begin
    pad_o = 1'b0;
    pad_oe_o = 1'b0;
    pad_pu_o = 1'b0;
    case (mode_i)
      CFGIO_QUASI: begin
        pad_oe_o = ~latch_i;
        pad_pu_o = latch_i;
      end
      CFGIO_PUSH: begin
        pad_oe_o = 1'b1;
        pad_o = latch_i;
      end
      CFGIO_OPEN: begin
        pad_oe_o = ~latch_i;
      end
      default: begin
        pad_oe_o = 1'b0;
      end
    endcase
  end

  // ==========================================================
  chk_quasi_weak_high: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_i == CFGIO_QUASI |->
      (latch_i ? (pad_pu_o && !pad_oe_o) : (pad_oe_o && !pad_o))
  ) else $error("Weak pull-up mode drives wrongly");

  chk_open_drain: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_i == CFGIO_OPEN |->
      !pad_pu_o && !pad_o && (pad_oe_o == !latch_i)
  ) else $error("Open drain mode drives wrongly");

  chk_push_pull: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_i == CFGIO_PUSH |-> pad_oe_o && pad_o == latch_i && !pad_pu_o
  ) else $error("Push-pull mode drives wrongly");

  chk_input_only: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_i == CFGIO_INPUT |-> !pad_oe_o && !pad_pu_o
  ) else $error("Input-only mode drives the pad");

endmodule

// file: design/cfgio_top.sv
/*
  Configurable I/O port block: four 8-bit ports with per-pin output
  types, port latches, glitch-suppressed inputs and a Wishbone slave.
  Assumes synchronous pin inputs, a synchronous active-high reset and
  static user configuration inputs.
*/
// Overview of operation
// - Four output types per pin, two bits each
// - Reset-capable pin is input only, never drives
// - Timer pin allows only input-only or open drain
// - Weak pull-up mode: one weak high, zero strong low
// - Open drain: no pull-up, drives low on zero
// - Push-pull drives latch value strongly both ways
// - Input-only drives nothing; inputs always deglitched
// - Analog pins drop output via input-only mode
// - Port 0 input disable bits, cleared by reset
// - Pins start input-only, then software configurable
// - Clock and reset pins withdrawn; 12 to 9
// - Three-port variant: reset pin gives 12 to 11
// - Reset pin resets when enabled or at power-up
`include "cfgio_map.svh"

module cfgio_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [31:0] pad_i,
  output logic [31:0] pad_o,
  output logic [31:0] pad_oe_o,
  output logic [31:0] pad_pu_o,
  input wire logic reset_pin_function_enable_i,
  input wire cfgio_pkg::cfgio_clksrc_e clk_src_i,
  input wire logic three_port_i,
  input wire logic por_active_i,
  output logic pin_reset_req_o
);
  import cfgio_pkg::*;

  localparam int unsigned GLITCH_CYC = `CFGIO_GLITCH_CYC;

  logic [7:0] latch_q [4];
  logic [7:0] cfga_q [4];
  logic [7:0] cfgb_q [4];
  logic [7:0] port0_digital_input_disable_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic rst_req_q;
  logic [31:0] usable;
  logic [31:0] level;
  logic [31:0] rd_level;
  logic [31:0] status;
  logic [5:0] usable_cnt;
  logic [1:0] bank;
  logic wr_take;
  cfgio_mode_e eff_mode [32];

  // ==========================================================
  // Pins present on the variant, minus those claimed by the
  // clock source or the external reset function
  always_comb begin
    usable = three_port_i ? `CFGIO_MASK_3P : `CFGIO_MASK_4P;
    if (reset_pin_function_enable_i) begin
      usable[`CFGIO_PIN_RST] = 1'b0;
    end
    if (!three_port_i && clk_src_i == CFGIO_CLK_EXTIN) begin
      usable[`CFGIO_PIN_XIN] = 1'b0;
    end else if (!three_port_i && clk_src_i == CFGIO_CLK_XTAL) begin
      usable[`CFGIO_PIN_XIN] = 1'b0;
      usable[`CFGIO_PIN_XOUT] = 1'b0;
    end
  end

  function automatic logic [5:0] count_ones(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h0;
    for (int i = 0; i < 32; i++) begin
      n = n + {5'h0, v[i]};
    end
    return n;
  endfunction

  assign usable_cnt = count_ones(usable);

  // ==========================================================
  // Effective output type per pin
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      eff_mode[i] = cfgio_mode_e'({cfga_q[i / 8][i % 8],
                                   cfgb_q[i / 8][i % 8]});
      if (!usable[i]) begin
        eff_mode[i] = CFGIO_INPUT;
      end
    end
    // Configuration stored for this pin is never used
    eff_mode[`CFGIO_PIN_RST] = CFGIO_INPUT;
    if (eff_mode[`CFGIO_PIN_TMR] == CFGIO_QUASI ||
        eff_mode[`CFGIO_PIN_TMR] == CFGIO_PUSH) begin
      eff_mode[`CFGIO_PIN_TMR] = CFGIO_INPUT;
    end
  end

  // ==========================================================
  // Per-pin driver decode and glitch suppression
  for (genvar g = 0; g < 32; g++) begin : g_pin
    cfgio_pin u_pin (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .mode_i(eff_mode[g]),
      .latch_i(latch_q[g / 8][g % 8]),
      .pad_o(pad_o[g]),
      .pad_oe_o(pad_oe_o[g]),
      .pad_pu_o(pad_pu_o[g])
    );
    cfgio_deglitch #(
      .CYC(GLITCH_CYC)
    ) u_dg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_i(pad_i[g]),
      .out_o(level[g])
    );
  end

  // Analog use of a pin removes its digital input on port 0
  always_comb begin
    rd_level = level & usable;
    rd_level[7:0] = rd_level[7:0] &
                    ~port0_digital_input_disable_q;
  end

  // ==========================================================
  // Wishbone slave: ack one cycle after the request, writes land
  // on the edge where the master samples ack
  assign bank = adr_i[3:2];
  assign wr_take = cyc_i && stb_i && we_i && ack_q && sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cyc_i && stb_i && !ack_q;
    end
  end

  always_comb begin
    status = 32'h0;
    status[`CFGIO_ST_CNT_LSB +: 6] = usable_cnt;
    status[`CFGIO_ST_RPE] = reset_pin_function_enable_i;
    status[`CFGIO_ST_CLK_LSB +: 2] = clk_src_i;
    status[`CFGIO_ST_3P] = three_port_i;
    status[`CFGIO_ST_POR] = por_active_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0;
    end else if (cyc_i && stb_i && !ack_q) begin
      dat_q <= 32'h0;
      if ((adr_i & `CFGIO_OFF_BANK_MASK) == `CFGIO_OFF_DATA) begin
        dat_q <= {24'h0, rd_level[bank * 8 +: 8]};
      end else if ((adr_i & `CFGIO_OFF_BANK_MASK) == `CFGIO_OFF_CFGA) begin
        dat_q <= {24'h0, cfga_q[bank]};
      end else if ((adr_i & `CFGIO_OFF_BANK_MASK) == `CFGIO_OFF_CFGB) begin
        dat_q <= {24'h0, cfgb_q[bank]};
      end else if (adr_i == `CFGIO_OFF_AIN_DIS) begin
        dat_q <= {24'h0, port0_digital_input_disable_q};
      end else if (adr_i == `CFGIO_OFF_STATUS) begin
        dat_q <= status;
      end
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ==========================================================
  // Port latches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < 4; p++) begin
        latch_q[p] <= `CFGIO_RST_LATCH;
      end
    end else if (wr_take &&
                 (adr_i & `CFGIO_OFF_BANK_MASK) == `CFGIO_OFF_DATA) begin
      latch_q[bank] <= dat_i[7:0];
    end
  end

  // ==========================================================
  // Output type registers, input-only after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < 4; p++) begin
        cfga_q[p] <= `CFGIO_RST_CFGA;
        cfgb_q[p] <= `CFGIO_RST_CFGB;
      end
    end else if (wr_take &&
                 (adr_i & `CFGIO_OFF_BANK_MASK) == `CFGIO_OFF_CFGA) begin
      cfga_q[bank] <= dat_i[7:0];
    end else if (wr_take &&
                 (adr_i & `CFGIO_OFF_BANK_MASK) == `CFGIO_OFF_CFGB) begin
      cfgb_q[bank] <= dat_i[7:0];
    end
  end

  // ==========================================================
  // Port 0 digital input disable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port0_digital_input_disable_q <= `CFGIO_RST_AIN_DIS;
    end else if (wr_take && adr_i == `CFGIO_OFF_AIN_DIS) begin
      port0_digital_input_disable_q <= dat_i[7:0];
    end
  end

  // ==========================================================
  // Reset pin function, filtered level keeps spikes out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_req_q <= 1'b0;
    end else begin
      rst_req_q <= !level[`CFGIO_PIN_RST] &&
                   (reset_pin_function_enable_i ||
                    por_active_i);
    end
  end

  assign pin_reset_req_o = rst_req_q;

  // ==========================================================
  sequence s_data_write;
    wr_take && (adr_i & `CFGIO_OFF_BANK_MASK) == `CFGIO_OFF_DATA;
  endsequence

  sequence s_cfg_kept(logic [7:0] a, logic [7:0] b, logic [1:0] p);
    cfga_q[p] == a && cfgb_q[p] == b;
  endsequence

  sequence s_bus_take;
    cyc_i && stb_i && !ack_o;
  endsequence

  chk_reset_pin_quiet: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !pad_oe_o[`CFGIO_PIN_RST] && !pad_pu_o[`CFGIO_PIN_RST]
  ) else $error("Reset-capable pin drives the pad");

  chk_timer_pin_types: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !pad_pu_o[`CFGIO_PIN_TMR] &&
    !(pad_oe_o[`CFGIO_PIN_TMR] && pad_o[`CFGIO_PIN_TMR])
  ) else $error("Timer pin pulls up or drives high");

  chk_ain_dis_reset: assert property (
    @(posedge clk_i)
    rst_i |=> port0_digital_input_disable_q == 8'h00
  ) else $error("Input disable bits not cleared by reset");

  chk_reset_input_only: assert property (
    @(posedge clk_i)
    rst_i |=> pad_oe_o == 32'h0 && pad_pu_o == 32'h0
  ) else $error("Pins not input-only after reset");

  chk_write_latch_only: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_data_write |=>
      s_cfg_kept($past(cfga_q[bank]), $past(cfgb_q[bank]), $past(bank))
      ##0 latch_q[$past(bank)] == $past(dat_i[7:0])
  ) else $error("Port write disturbed configuration or missed latch");

  chk_usable_count: assert property (
    @(posedge clk_i) disable iff (rst_i)
    usable_cnt == 6'd12 - 6'(reset_pin_function_enable_i) -
      (three_port_i ? 6'd0 :
       clk_src_i == CFGIO_CLK_EXTIN ? 6'd1 :
       clk_src_i == CFGIO_CLK_XTAL ? 6'd2 : 6'd0)
  ) else $error("Usable pin count wrong");

  chk_three_port_count: assert property (
    @(posedge clk_i) disable iff (rst_i)
    three_port_i |->
      usable_cnt == (reset_pin_function_enable_i ? 6'd11 : 6'd12)
  ) else $error("Three-port pin count wrong");

  chk_pin_reset_req: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 pin_reset_req_o == $past(!level[`CFGIO_PIN_RST] &&
      (reset_pin_function_enable_i || por_active_i))
  ) else $error("Reset request does not follow reset pin");

  chk_ack_one_cycle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o
  ) else $error("Ack held longer than one cycle");

  chk_ack_follows_req: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_bus_take |=> ack_o
  ) else $error("Request not acknowledged in the next cycle");

  chk_read_data_held: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i && !ack_o) |=> $stable(dat_o)
  ) else $error("Read data changed without a request");

  chk_withdrawn_quiet: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pad_oe_o & ~usable) == 32'h0 && (pad_pu_o & ~usable) == 32'h0
  ) else $error("Withdrawn pin drives the pad");

  chk_ain_dis_blocks: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_level[7:0] & port0_digital_input_disable_q) == 8'h00
  ) else $error("Disabled digital input still reads a level");

  chk_read_pin_level: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_bus_take ##0
      (!we_i && (adr_i & `CFGIO_OFF_BANK_MASK) == `CFGIO_OFF_DATA) |=>
      dat_o == {24'h0, $past(rd_level[bank * 8 +: 8])}
  ) else $error("Port read does not return pin levels");

  chk_timer_open_drain: assert property (
    @(posedge clk_i) disable iff (rst_i)
    {cfga_q[`CFGIO_PIN_TMR / 8][`CFGIO_PIN_TMR % 8],
     cfgb_q[`CFGIO_PIN_TMR / 8][`CFGIO_PIN_TMR % 8]} == CFGIO_OPEN |->
      pad_oe_o[`CFGIO_PIN_TMR] ==
        !latch_q[`CFGIO_PIN_TMR / 8][`CFGIO_PIN_TMR % 8]
  ) else $error("Timer pin open drain does not follow latch");

  chk_req_idle_low: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !reset_pin_function_enable_i && !por_active_i |=> !pin_reset_req_o
  ) else $error("Reset request raised while the pin is a plain input");

endmodule

// file: testbench/cfgio_ext_dev.sv
/*
  Model of the devices on the port pins and of the resolved pin wire.
  Assumes the bench drives ext_en_i and ext_val_i by non-blocking
  assignment at the rising clock edge.
*/
module cfgio_ext_dev (
  input wire logic clk_i,
  input wire logic [31:0] pad_i,
  input wire logic [31:0] oe_i,
  input wire logic [31:0] pu_i,
  input wire logic [31:0] ext_en_i,
  input wire logic [31:0] ext_val_i,
  output logic [31:0] lvl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] wire_v;
  // ==========================================================
  // Wire resolution
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (oe_i[i]) wire_v[i] = pad_i[i];
      else if (ext_en_i[i]) wire_v[i] = ext_val_i[i];
      else if (pu_i[i]) wire_v[i] = 1'b1;
      // Floating pin: toggles so no stale level can pass for a drive
      else wire_v[i] = ~lvl_o[i];
    end
  end
  // ==========================================================
  // Registered so the block sees levels synchronous to its clock
  initial begin
    lvl_o = '0;
    forever @(posedge clk_i) lvl_o <= wire_v;
  end
endmodule

// file: testbench/tb.sv
/*
  Self-checking bench of the configurable I/O port block.
  Assumes the block, its package and the pin model are compiled first.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cfgio_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 0;
  logic [31:0] dat = 0, dat_o, pad_i, pad_o, pad_oe, pad_pu;
  logic [31:0] ext_en = 0, ext_val = 0;
  logic ack, reset_pin_function_enable = 0, tp = 0, por = 0, rreq;
  logic [3:0] sel = 4'h1;
  cfgio_clksrc_e cs = CFGIO_CLK_ONCHIP;
  int mismatches = 0, n_compared = 0;
  cfgio_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack), .pad_i(pad_i), .pad_o(pad_o),
    .pad_oe_o(pad_oe), .pad_pu_o(pad_pu),
    .reset_pin_function_enable_i(reset_pin_function_enable), .clk_src_i(cs),
    .three_port_i(tp), .por_active_i(por), .pin_reset_req_o(rreq));
  cfgio_ext_dev u_ext (.clk_i(clk_i), .pad_i(pad_o), .oe_i(pad_oe),
    .pu_i(pad_pu), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .lvl_o(pad_i));
  initial forever #20 clk_i = ~clk_i;
  // ==========================================================
  // Checks and bus cycles
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Classic cycle: hold until ack is seen high at a rising edge
  task automatic wb(logic w, logic [7:0] a, logic [7:0] d,
                    output logic [31:0] r);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    // Only the watchdog ends a wait for an answer that never comes
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = dat_o;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge clk_i);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic [31:0] r;
    wb(1, a, d, r);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    logic [31:0] r;
    wb(0, a, 8'h00, r);
    chk($sformatf("reg %h", a), r, e);
  endtask
  // {oe, pu, out} expected for one pin
  function automatic logic [2:0] pexp(int idx, logic [1:0] m, logic l);
    if (idx == 13 || (idx == 10 && !m[1])) m = 2'b10;
    case (m)
      2'b00: return {~l, l, 1'b0};
      2'b01: return {1'b1, 1'b0, l};
      2'b10: return 3'b000;
      default: return {~l, 2'b00};
    endcase
  endfunction
  function automatic logic [5:0] ucnt(logic t, logic r, logic [1:0] c);
    ucnt = 6'd12 - 6'(r);
    if (!t && c == 2'b01) ucnt = ucnt - 6'd1;
    if (!t && c == 2'b10) ucnt = ucnt - 6'd2;
  endfunction
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    test_done();
  end
  // ==========================================================
  // Scenarios
  initial begin
    logic [31:0] r;
    logic [7:0] lat, v, d, pa, eo, ep, ex;
    logic [2:0] e;
    logic [1:0] mm;
    logic [3:0] q;
    void'($urandom(32'h7547));
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk("oe", pad_oe, 0);
    chk("pu", pad_pu, 0);
    rd(8'h10, 32'hff);
    rd(8'h30, 0);
    rd(8'h40, 0);
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        mm = 2'(m);
        pa = 8'(4 * p);
        lat = 8'($urandom);
        wr(8'h10 + pa, {8{mm[1]}});
        wr(8'h20 + pa, {8{mm[0]}});
        wr(pa, lat);
        rd(8'h20 + pa, {24'h0, {8{mm[0]}}});
        eo = 0;
        ep = 0;
        ex = 0;
        for (int b = 0; b < 8; b++) begin
          if ((p == 1 ? 8'h3c : 8'h3f) & (8'h01 << b)) begin
            e = pexp(p * 8 + b, mm, lat[b]);
            eo[b] = e[2];
            ep[b] = e[1];
            ex[b] = e[0] & e[2];
          end
        end
        chk("oe", pad_oe[p*8+:8], eo);
        chk("pu", pad_pu[p*8+:8], ep);
        chk("out", pad_o[p*8+:8] & pad_oe[p*8+:8], ex);
      end
    end
    wr(8'h10, 8'h00);
    wr(8'h20, 8'h00);
    wr(8'h00, 8'hff);
    v = 8'($urandom);
    ext_en <= 32'h3f;
    ext_val <= {24'h0, v};
    repeat (6) @(posedge clk_i);
    rd(8'h00, v & 8'h3f);
    ext_val[3] <= ~v[3];
    @(posedge clk_i);
    ext_val[3] <= v[3];
    repeat (6) @(posedge clk_i);
    rd(8'h00, v & 8'h3f);
    d = 8'($urandom);
    wr(8'h30, d);
    rd(8'h00, v & ~d & 8'h3f);
    sel <= 4'h0;
    wr(8'h30, ~d);
    sel <= 4'h1;
    rd(8'h30, {24'h0, d});
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(8'h30, 0);
    ext_en[13] <= 1;
    for (int i = 0; i < 4; i++) begin
      {por, reset_pin_function_enable} <= 2'(i);
      repeat (8) @(posedge clk_i);
      chk("rreq", rreq, 32'(i != 0));
    end
    ext_val[13] <= 1;
    repeat (8) @(posedge clk_i);
    chk("rreq", rreq, 0);
    por <= 0;
    for (int i = 0; i < 16; i++) begin
      q = 4'(i);
      tp <= q[3];
      reset_pin_function_enable <= q[2];
      cs <= cfgio_clksrc_e'(q[1:0]);
      repeat (4) @(posedge clk_i);
      wb(0, 8'h34, 8'h00, r);
      chk("count", r[5:0], ucnt(q[3], q[2], q[1:0]));
      chk("fields", r[10:6], {1'b0, q[3], q[1:0], q[2]});
    end
    test_done();
  end
endmodule
